/* File: logic/controller_error_manager.sv */
// error classification, indicators and error store of the controller
// assumes single-cycle instruction and event strobes from the scan engine
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

module controller_error_manager
#(
  parameter int FLASH_HALF_CYC = ctrl_err_pkg::FLASH_HALF_CYC,
  parameter int QDEPTH = ctrl_err_pkg::QUEUE_DEPTH
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire logic [ctrl_err_pkg::ADDR_W-1:0] regAddr,
  input wire logic [ctrl_err_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [ctrl_err_pkg::DATA_W-1:0] regRdata,
  // program instructions
  input wire logic nfAlarmExec,
  input wire logic fAlarmExec,
  input wire logic [7:0] alarmCode,
  input wire logic msgExec,
  input wire logic [15:0] msgWord,
  // supervision
  input wire logic scanEnd,
  input wire logic [7:0] cycleMs,
  input wire logic ioTableMismatch,
  input wire logic remoteLinkFault,
  input wire logic remoteMaster,
  input wire logic unitFault,
  input wire logic [7:0] unitNum,
  input wire logic batteryLow,
  input wire logic hwFatal,
  // initialization
  input wire logic startInput,
  input wire logic remotePowered,
  input wire logic terminatorSeen,
  // programming terminal
  input wire logic monitorKey,
  input wire logic clearKey,
  output logic termMsgValid,
  output logic [15:0] termMsg,
  output logic [7:0] termCode,
  output logic noErrorReport,
  output logic termRefused,
  // indicators and outputs
  output logic powerLed,
  output logic runLed,
  output logic alarmLed,
  output logic runOutput,
  output logic outputsOn,
  output logic execRun,
  output logic [7:0] errorCodeField,
  output logic [7:0] auxUnitWord,
  output logic [15:0] unitRestart
);
  import ctrl_err_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  run_state_t state_q;
  run_state_t state_d;
  op_mode_t mode_q;
  logic [7:0] field_q;
  logic [7:0] field_d;
  logic [PEND_N-1:0] pend_q;
  logic [7:0] userCode_q;
  logic rmtMaster_q;
  logic [7:0] aux_q;
  logic [15:0] restart_q;
  logic battPrev_q;
  logic ovf_q;
  logic refused_q;
  logic msgValid_q;
  logic [15:0] msg_q;
  logic [15:0] rdata_q;
  logic flashOn;
  logic [7:0] qHead;
  logic qEmpty;
  logic qFull;

  // ----------------------------------------
  // event decode
  // ----------------------------------------
  // instructions only count once the scan is executing
  wire running = (state_q == ST_RUNNING);
  wire progMode = (mode_q == MODE_PROGRAM);
  wire inSlow = (cycleMs >= WDT_SLOW_LO_MS) && (cycleMs <= WDT_SLOW_HI_MS);
  wire fatalInstr = running && fAlarmExec;
  wire fatalGo = running && (hwFatal || fAlarmExec);
  wire [7:0] fatalCode = inSlow ? CODE_SLOW : alarmCode;
  wire nfUser = running && nfAlarmExec && user_code_ok(alarmCode);
  wire nfZero = running && nfAlarmExec && (alarmCode == CODE_NONE);
  wire slowScan = running && scanEnd && (cycleMs > WDT_WARN_MS);
  wire battRise = batteryLow && !battPrev_q;
  wire clearGo = clearKey && progMode;
  wire monPop = monitorKey && progMode;
  wire monRot = monitorKey && !progMode;

  // new pending events, set wins over the service clear
  wire [PEND_N-1:0] pendSet = {
    running && battRise,
    running && unitFault,
    running && remoteLinkFault,
    running && ioTableMismatch,
    slowScan,
    nfUser};

  // lowest set pending slot
  function automatic logic [PEND_N-1:0] first_set(input logic [PEND_N-1:0] v);
    return v & (~v + PEND_N'(1));
  endfunction

  // ----------------------------------------
  // field arbitration
  // ----------------------------------------
  // one field action per cycle: clear, fatal write, code zero, monitor, pending
  wire busyOther = clearGo || fatalInstr || nfZero || monitorKey;
  wire [PEND_N-1:0] grant = busyOther ? '0 : first_set(pend_q);
  wire svc = |grant;
  wire [7:0] rmtCode = {CODE_RMT[7:1], rmtMaster_q};
  wire [7:0] pendCode =
    grant[P_USER] ? userCode_q :
    grant[P_CYCLE] ? CODE_CYCLE :
    grant[P_IOTAB] ? CODE_IOTAB :
    grant[P_RMT] ? rmtCode :
    grant[P_UNIT] ? CODE_UNIT : CODE_BATT;
  wire loadGo = !clearGo && (fatalInstr || svc);
  wire [7:0] loadCode = fatalInstr ? fatalCode : pendCode;
  wire popGo = !clearGo && !fatalInstr && (nfZero || monPop);
  wire rotGo = !clearGo && !fatalInstr && !nfZero && monRot && (field_q != CODE_NONE);
  // a displaced code goes behind the others; loss only when the store is full
  wire qPush = (loadGo && (field_q != CODE_NONE)) || (rotGo && !qEmpty);
  wire qPop = popGo || (rotGo && !qEmpty);
  wire qDrop = qPush && qFull && !qPop;

  // next field value
  always_comb
  begin
    field_d = field_q;
    if (clearGo)
      field_d = CODE_NONE;
    else if (loadGo)
      field_d = loadCode;
    else if (popGo)
      field_d = qEmpty ? CODE_NONE : qHead;
    else if (rotGo && !qEmpty)
      field_d = qHead;
  end

  // ----------------------------------------
  // run state
  // ----------------------------------------
  // fatal wins over every non-fatal condition
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_INIT_WAIT:
        if (startInput && remotePowered && terminatorSeen)
          state_d = ST_RUNNING;
      ST_RUNNING:
        if (fatalGo)
          state_d = ST_HALTED;
      ST_HALTED:
        if (clearGo && !hwFatal)
          state_d = ST_INIT_WAIT;
    endcase
  end

  // state and field registers
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state_q <= ST_INIT_WAIT;
      field_q <= CODE_NONE;
    end
    else
    begin
      state_q <= state_d;
      field_q <= field_d;
    end
  end

  // pending events and their captured details
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      pend_q <= '0;
    else
      pend_q <= (clearGo ? '0 : (pend_q & ~grant)) | pendSet; // an event outlives a clear
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      userCode_q <= CODE_NONE;
      rmtMaster_q <= 1'b0;
      aux_q <= 8'h00;
      battPrev_q <= 1'b0;
    end
    else
    begin
      if (pendSet[P_USER])
        userCode_q <= alarmCode;
      if (pendSet[P_RMT])
        rmtMaster_q <= remoteMaster;
      if (pendSet[P_UNIT])
        aux_q <= unitNum;
      battPrev_q <= batteryLow;
    end
  end

  // ----------------------------------------
  // terminal side
  // ----------------------------------------
  // refusal and message strobes last one cycle
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      refused_q <= 1'b0;
      msgValid_q <= 1'b0;
      msg_q <= 16'h0000;
      ovf_q <= 1'b0;
    end
    else
    begin
      refused_q <= clearKey && !progMode;
      msgValid_q <= running && msgExec;
      if (running && msgExec)
        msg_q <= msgWord;
      ovf_q <= clearGo ? 1'b0 : (ovf_q || qDrop);
    end
  end

  err_queue #(
    .W(8),
    .DEPTH(QDEPTH)
  ) u_store (
    .clk(ref_clk),
    .nrst(nrst),
    .push(qPush),
    .pushData(field_q),
    .pop(qPop),
    .flush(clearGo),
    .head(qHead),
    .empty(qEmpty),
    .full(qFull)
  );

  flash_gen #(
    .HALF_CYC(FLASH_HALF_CYC)
  ) u_flash (
    .clk(ref_clk),
    .nrst(nrst),
    .flashOn(flashOn)
  );

  // ----------------------------------------
  // register port
  // ----------------------------------------
  wire [15:0] statusWord = {11'h000, state_q == ST_INIT_WAIT, ovf_q,
    noErrorReport, field_q != CODE_NONE, state_q == ST_HALTED};
  wire [15:0] rdMux =
    (regAddr == ADDR_STATUS) ? statusWord :
    (regAddr == ADDR_CODE) ? {8'h00, field_q} :
    (regAddr == ADDR_AUX) ? {8'h00, aux_q} :
    (regAddr == ADDR_RESTART) ? restart_q :
    (regAddr == ADDR_MODE) ? {14'h0000, mode_q} : 16'h0000;
  wire modeWr = regWr && (regAddr == ADDR_MODE) && (regWdata[1:0] != 2'h3);

  // writable registers; an illegal mode code is ignored
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      mode_q <= MODE_PROGRAM;
      restart_q <= RESTART_RST;
      rdata_q <= 16'h0000;
    end
    else
    begin
      if (modeWr)
        mode_q <= op_mode_t'(regWdata[1:0]);
      if (regWr && (regAddr == ADDR_RESTART))
        restart_q <= regWdata;
      rdata_q <= regRd ? rdMux : 16'h0000;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // no power-loss detection here, so power stays lit
  assign powerLed = 1'b1;
  assign runLed = running;
  assign runOutput = running;
  assign outputsOn = running;
  assign execRun = running;
  assign alarmLed = (state_q == ST_HALTED) ? 1'b1 :
    ((field_q != CODE_NONE) && flashOn);
  assign noErrorReport = (field_q == CODE_NONE) && qEmpty
    && (state_q != ST_HALTED);
  assign termCode = field_q;
  assign termRefused = refused_q;
  assign termMsgValid = msgValid_q;
  assign termMsg = msg_q;
  assign errorCodeField = field_q;
  assign auxUnitWord = aux_q;
  assign unitRestart = restart_q;
  assign regRdata = rdata_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_fatal_outputs: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_q == ST_HALTED) |-> alarmLed && powerLed && !runOutput && !outputsOn)
    else $error("fatal state without steady alarm and outputs off");
  a_fatal_entry: assert property (@(posedge ref_clk) disable iff (!nrst)
    (running && fAlarmExec) |=> (state_q == ST_HALTED) && !execRun)
    else $error("fatal alarm did not halt execution");
  a_fatal_code: assert property (@(posedge ref_clk) disable iff (!nrst)
    (running && fAlarmExec && !clearGo && inSlow) |=> (errorCodeField == CODE_SLOW))
    else $error("slow scan fatal alarm did not write 9f");
  a_init_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_q == ST_INIT_WAIT) |-> powerLed && !runLed && !runOutput)
    else $error("init wait indicators wrong");
  a_start_wait: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_q == ST_INIT_WAIT && (!startInput || !remotePowered)) |=> !running)
    else $error("execution started without start input or remote power");
  a_clear_refuse: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clearKey && !progMode && !nfZero && !fAlarmExec && !monitorKey && !svc)
    |=> termRefused && (errorCodeField == $past(errorCodeField)))
    else $error("clear accepted outside program mode");
  a_clear_report: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clearKey && progMode && !hwFatal) |=> noErrorReport)
    else $error("no-error report missing after clear");
  a_cycle_warn: assert property (@(posedge ref_clk) disable iff (!nrst)
    (running && scanEnd && cycleMs > WDT_WARN_MS && !clearGo) |=> pend_q[P_CYCLE])
    else $error("long scan not flagged");
  a_nonfatal_run: assert property (@(posedge ref_clk) disable iff (!nrst)
    (running && !hwFatal && !fAlarmExec) |=> runOutput && runLed)
    else $error("run output dropped on non-fatal error");
endmodule

/* File: logic/ctrl_err_pkg.sv */
// constants, codes and types shared by the controller error manager
// assumes a single 10 MHz clock and a plain register port
package ctrl_err_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int FLASH_HALF_MS = 500;
  localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam logic [7:0] WDT_WARN_MS = 8'h64;
  localparam logic [7:0] WDT_SLOW_LO_MS = 8'h78;
  localparam logic [7:0] WDT_SLOW_HI_MS = 8'h82;

  // ----------------------------------------
  // error codes
  // ----------------------------------------
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_CYCLE = 8'hf8;
  localparam logic [7:0] CODE_IOTAB = 8'he7;
  localparam logic [7:0] CODE_RMT = 8'hb0;
  localparam logic [7:0] CODE_UNIT = 8'hd0;
  localparam logic [7:0] CODE_BATT = 8'hf7;
  localparam logic [7:0] CODE_SLOW = 8'h9f;

  // ----------------------------------------
  // register map and fields
  // ----------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_CODE = 3'h1;
  localparam logic [2:0] ADDR_AUX = 3'h2;
  localparam logic [2:0] ADDR_RESTART = 3'h3;
  localparam logic [2:0] ADDR_MODE = 3'h4;
  localparam int ST_FATAL = 0;
  localparam int ST_NONFATAL = 1;
  localparam int ST_NOERR = 2;
  localparam int ST_OVF = 3;
  localparam int ST_WAIT = 4;
  localparam logic [15:0] RESTART_RST = 16'h0000;
  localparam int QUEUE_DEPTH = 8;

  // pending event slots, lowest index served first
  localparam int PEND_N = 6;
  localparam int P_USER = 0;
  localparam int P_CYCLE = 1;
  localparam int P_IOTAB = 2;
  localparam int P_RMT = 3;
  localparam int P_UNIT = 4;
  localparam int P_BATT = 5;

  typedef enum logic [1:0] {MODE_PROGRAM, MODE_MONITOR, MODE_RUN} op_mode_t;
  typedef enum logic [1:0] {ST_INIT_WAIT, ST_RUNNING, ST_HALTED} run_state_t;

  // user codes are two decimal digits, 01 to 99
  function automatic logic user_code_ok(input logic [7:0] c);
    return (c[7:4] <= 4'h9) && (c[3:0] <= 4'h9) && (c != CODE_NONE);
  endfunction

endpackage

/* File: logic/err_queue.sv */
// store of queued error codes behind the current error field
// push and pop may come together; flush empties the store
`timescale 1ns/1ps
module err_queue
#(
  parameter int W = 8,
  parameter int DEPTH = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic push,
  input wire logic [W-1:0] pushData,
  input wire logic pop,
  input wire logic flush,
  // status
  output logic [W-1:0] head,
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] rdPtr_q;
  logic [AW-1:0] wrPtr_q;
  logic [AW:0] count_q;
  wire doPop = pop && !empty;
  wire doPush = push && (!full || doPop);

  assign head = mem[rdPtr_q];
  assign empty = (count_q == '0);
  assign full = (count_q == (AW+1)'(DEPTH));

  // storage has no reset; only the pointers and the count carry state
  always_ff @(posedge clk)
  begin
    if (doPush)
      mem[wrPtr_q] <= pushData;
  end

  // pointers wrap at a power-of-two depth
  always_ff @(posedge clk)
  begin
    if (!nrst || flush)
    begin
      rdPtr_q <= '0;
      wrPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      rdPtr_q <= rdPtr_q + AW'(doPop);
      wrPtr_q <= wrPtr_q + AW'(doPush);
      count_q <= count_q + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule

/* File: logic/flash_gen.sv */
// free running square wave for the flashing alarm indication
// assumes the half period is at least two cycles
`timescale 1ns/1ps
module flash_gen
#(
  parameter int HALF_CYC = 5_000_000
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // wave
  output logic flashOn
);
  logic [31:0] cnt_q;
  logic flash_q;
  wire wrap = (cnt_q == 32'(HALF_CYC - 1));

  assign flashOn = flash_q;

  // toggle once per half period
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_q <= '0;
      flash_q <= 1'b0;
    end
    else
    begin
      cnt_q <= wrap ? '0 : cnt_q + 32'h1;
      flash_q <= flash_q ^ wrap;
    end
  end
endmodule

/* File: verification/controller_error_manager_tb.sv */
// self-checking bench for the controller error manager
// assumes a 10 MHz clock and a shortened flash half period of four cycles
`timescale 1ns/1ps
module controller_error_manager_tb;
  import ctrl_err_pkg::*;
  localparam int HALF = 4;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] regAddr = 3'h0;
  logic [DATA_W-1:0] regWdata = 16'h0000;
  logic regWr = 1'b0, regRd = 1'b0;
  logic [DATA_W-1:0] regRdata;
  logic nfAlarmExec = 1'b0, fAlarmExec = 1'b0, msgExec = 1'b0, scanEnd = 1'b0;
  logic [7:0] alarmCode = 8'h00, cycleMs = 8'h0a, unitNum = 8'h00;
  logic [15:0] msgWord = 16'h0000;
  logic ioTableMismatch = 1'b0, remoteLinkFault = 1'b0, remoteMaster = 1'b0;
  logic unitFault = 1'b0, batteryLow = 1'b0, hwFatal = 1'b0;
  logic startInput = 1'b0, remotePowered = 1'b0, terminatorSeen = 1'b0;
  logic monitorKey, clearKey, termMsgValid, noErrorReport, termRefused;
  logic [15:0] termMsg, unitRestart;
  logic [7:0] termCode, errorCodeField, auxUnitWord;
  logic powerLed, runLed, alarmLed, runOutput, outputsOn, execRun;
  logic [15:0] rdv;
  logic [7:0] exp_codes [5] = '{8'hf8, 8'he7, 8'hb0, 8'hb1, 8'hd0};
  int error_cnt = 0;
  int compares = 0;
  int hi;

  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end

  controller_error_manager #(.FLASH_HALF_CYC(HALF), .QDEPTH(8)) dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .nfAlarmExec(nfAlarmExec),
    .fAlarmExec(fAlarmExec), .alarmCode(alarmCode), .msgExec(msgExec), .msgWord(msgWord),
    .scanEnd(scanEnd), .cycleMs(cycleMs), .ioTableMismatch(ioTableMismatch),
    .remoteLinkFault(remoteLinkFault), .remoteMaster(remoteMaster), .unitFault(unitFault),
    .unitNum(unitNum), .batteryLow(batteryLow), .hwFatal(hwFatal), .startInput(startInput),
    .remotePowered(remotePowered), .terminatorSeen(terminatorSeen),
    .monitorKey(monitorKey), .clearKey(clearKey), .termMsgValid(termMsgValid),
    .termMsg(termMsg), .termCode(termCode), .noErrorReport(noErrorReport),
    .termRefused(termRefused), .powerLed(powerLed), .runLed(runLed), .alarmLed(alarmLed),
    .runOutput(runOutput), .outputsOn(outputsOn), .execRun(execRun),
    .errorCodeField(errorCodeField), .auxUnitWord(auxUnitWord), .unitRestart(unitRestart));

  term_model term_u (.ref_clk(ref_clk), .termMsgValid(termMsgValid), .termMsg(termMsg),
    .termRefused(termRefused), .monitorKey(monitorKey), .clearKey(clearKey));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic summarize();
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // waits n edges, then lets that edge's updates land
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask

  // one-cycle strobe on an instruction or event input
  task automatic ev(input int which);
    @(posedge ref_clk);
    case (which)
      0: nfAlarmExec <= 1'b1;
      1: fAlarmExec <= 1'b1;
      2: msgExec <= 1'b1;
      3: scanEnd <= 1'b1;
      4: ioTableMismatch <= 1'b1;
      5: remoteLinkFault <= 1'b1;
      default: unitFault <= 1'b1;
    endcase
    @(posedge ref_clk);
    {nfAlarmExec, fAlarmExec, msgExec, scanEnd} <= 4'h0;
    {ioTableMismatch, remoteLinkFault, unitFault} <= 3'h0;
  endtask

  // start-up can take a few cycles; a hang is cut short here
  task automatic wait_run();
    int i;
    for (i = 0; i < 20 && execRun !== 1'b1; i++)
      settle(1);
    if (execRun !== 1'b1)
    begin
      error_cnt++;
      summarize();
    end
  endtask

  // counts alarm indicator high cycles over one flash period
  task automatic count_alarm();
    hi = 0;
    repeat (2 * HALF)
    begin
      settle(1);
      if (alarmLed === 1'b1)
        hi++;
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    settle(3);
    chk("powerLed", powerLed, 1'b1);
    chk("runOutput", {runLed, runOutput, execRun}, 3'h0);
    chk("field init", errorCodeField, CODE_NONE);
    startInput <= 1'b1;
    remotePowered <= 1'b1;
    settle(4);
    chk("no terminator", execRun, 1'b0);
    rd(ADDR_STATUS, rdv);
    chk("status wait", rdv[ST_WAIT], 1'b1);
    terminatorSeen <= 1'b1;
    wait_run();
    rd(3'h5, rdv);
    chk("unmapped", rdv, 16'h0000);
    wr(ADDR_CODE, 16'h00aa);
    settle(1);
    chk("field ro", errorCodeField, CODE_NONE);
    // user codes: a bad digit is ignored, a valid one kept without stopping
    alarmCode <= 8'h3a;
    ev(0);
    settle(2);
    chk("bad code", errorCodeField, CODE_NONE);
    alarmCode <= 8'h25;
    ev(0);
    settle(2);
    chk("user code", errorCodeField, 8'h25);
    chk("nonfatal run", {powerLed, runLed, runOutput, outputsOn}, 4'hf);
    chk("run output", runOutput, 1'b1);
    count_alarm();
    chk("flash", hi, 2 * HALF / 2);
    // supervision events, one at a time so priority plays no part
    cycleMs <= 8'h64;
    ev(3);
    settle(2);
    chk("100 ms", errorCodeField, 8'h25);
    cycleMs <= 8'h65;
    for (int k = 0; k < 5; k++)
    begin
      remoteMaster <= (k == 3);
      unitNum <= 8'h07;
      ev(k == 0 ? 3 : k == 1 ? 4 : k == 4 ? 6 : 5);
      settle(2);
      chk("event code", errorCodeField, exp_codes[k]);
    end
    cycleMs <= 8'h0a;
    chk("aux unit", auxUnitWord, 8'h07);
    batteryLow <= 1'b1;
    settle(3);
    chk("battery", errorCodeField, CODE_BATT);
    chk("still running", execRun, 1'b1);
    // run mode: clear refused, monitor rotates through the store
    wr(ADDR_MODE, 16'h0002);
    wr(ADDR_MODE, 16'h0003);
    rd(ADDR_MODE, rdv);
    chk("mode", rdv, 16'h0002);
    term_u.press_clear();
    settle(2);
    chk("refused", term_u.refusedCnt, 1);
    chk("kept", errorCodeField, CODE_BATT);
    term_u.press_monitor();
    settle(0);
    chk("rotate", termCode, 8'h25);
    alarmCode <= 8'h00;
    ev(0);
    settle(0);
    chk("code zero", errorCodeField, 8'hf8);
    msgWord <= 16'h5a3c;
    ev(2);
    settle(1);
    chk("message", term_u.lastMsg, 16'h5a3c);
    // program mode: reading removes, clear empties the store
    wr(ADDR_MODE, 16'h0000);
    term_u.press_monitor();
    settle(0);
    chk("remove", errorCodeField, 8'he7);
    chk("message count", term_u.msgCnt, 1);
    term_u.press_clear();
    settle(0);
    chk("cleared", {errorCodeField, 7'h00, noErrorReport}, 16'h0001);
    chk("not refused", term_u.refusedCnt, 1);
    rd(ADDR_STATUS, rdv);
    chk("status clear", rdv, 16'h0004);
    // ten user codes overrun a store of eight behind the field
    for (int k = 0; k < 10; k++)
    begin
      alarmCode <= 8'h10 + 8'(k);
      ev(0);
      settle(2);
    end
    chk("last user code", errorCodeField, 8'h19);
    rd(ADDR_STATUS, rdv);
    chk("status overflow", rdv, 16'h000a);
    batteryLow <= 1'b0;
    // fatal alarm over a non-fatal code already in the field
    alarmCode <= 8'h11;
    ev(0);
    settle(2);
    alarmCode <= 8'h42;
    ev(1);
    settle(0);
    chk("fatal code", errorCodeField, 8'h42);
    chk("fatal stop", {runOutput, outputsOn, execRun, powerLed}, 4'h1);
    count_alarm();
    chk("steady", hi, 2 * HALF);
    ev(4);
    settle(2);
    chk("halted ignore", errorCodeField, 8'h42);
    rd(ADDR_STATUS, rdv);
    chk("status fatal", rdv[ST_FATAL], 1'b1);
    term_u.press_clear();
    wait_run();
    // fatal alarm with slow scan
    cycleMs <= 8'h7d;
    alarmCode <= 8'h33;
    ev(1);
    settle(0);
    chk("slow scan", errorCodeField, CODE_SLOW);
    term_u.press_clear();
    wait_run();
    // hardware fatal stops without a code
    hwFatal <= 1'b1;
    settle(2);
    chk("hw fatal", {execRun, outputsOn, errorCodeField}, 10'h000);
    hwFatal <= 1'b0;
    term_u.press_clear();
    wait_run();
    // software restarts a unit through its restart bit
    wr(ADDR_RESTART, 16'h0004);
    settle(0);
    chk("restart", unitRestart, 16'h0004);
    rd(ADDR_RESTART, rdv);
    chk("restart rd", rdv, 16'h0004);
    summarize();
  end
endmodule

/* File: verification/term_model.sv */
// programming terminal model: presses monitor and clear keys, keeps messages seen
// assumes the manager answers on the cycle after a key and pulses for one cycle
`timescale 1ns/1ps
module term_model
(
  // clock
  input wire logic ref_clk,
  // from the manager
  input wire logic termMsgValid,
  input wire logic [15:0] termMsg,
  input wire logic termRefused,
  // keys
  output logic monitorKey,
  output logic clearKey
);
  logic [15:0] lastMsg = 16'h0000;
  int msgCnt = 0;
  int refusedCnt = 0;

  initial
  begin
    monitorKey = 1'b0;
    clearKey = 1'b0;
  end

  // one key press lasts exactly one cycle; repeated presses step through the store
  task automatic press_monitor();
    @(posedge ref_clk);
    monitorKey <= 1'b1;
    @(posedge ref_clk);
    monitorKey <= 1'b0;
  endtask

  // clearing is only asked for; the manager decides whether the mode allows it
  task automatic press_clear();
    @(posedge ref_clk);
    clearKey <= 1'b1;
    @(posedge ref_clk);
    clearKey <= 1'b0;
  endtask

  // pulses stand one cycle, so they are caught on every edge
  always @(posedge ref_clk)
  begin
    if (termMsgValid === 1'b1)
    begin
      lastMsg <= termMsg;
      msgCnt <= msgCnt + 1;
    end
    if (termRefused === 1'b1)
      refusedCnt <= refusedCnt + 1;
  end
endmodule
